// ### hw/anchor_defines.svh
// constants for the hibernation anchor tracker
`ifndef ANCHOR_DEFINES_SVH
`define ANCHOR_DEFINES_SVH
`define ANC_REG_CTRL        32'h0000_0000
`define ANC_REG_STATUS      32'h0000_0004
`define ANC_REG_VALID       32'h0000_0008
`define ANC_REG_ENTRY_SEL   32'h0000_000c
`define ANC_REG_ENTRY_DATA  32'h0000_0010
`define ANC_CTRL_CAPABLE    0
`define ANC_CTRL_MASTER     1
`define ANC_CTRL_RESET_VAL  2'h2
`define ANC_LOST_BEACON_LIMIT 4'h3
`endif

// ### hw/anchor_pkg.sv
// types for the hibernation anchor tracker
package anchor_pkg;
  typedef enum logic [1:0] {
    ENTRY_FREE,
    ENTRY_PENDING,
    ENTRY_SLEEPING
  } entry_state_t;
endpackage

// ### hw/hibernation_anchor_tracker.sv
// hibernation anchor tracker: neighbour table, countdowns, beacon element view, ahb-lite regs
`timescale 1ns/100ps
`include "anchor_defines.svh"
module hibernation_anchor_tracker #(
  parameter int ENTRIES  = 8,
  parameter int ADDR_W   = 16,
  parameter int CNT_W    = 8,
  parameter int HCD_W    = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  // beacon receive path
  input  wire logic              rx_beacon_i,
  input  wire logic [ADDR_W-1:0] rx_addr_i,
  input  wire logic              rx_hib_ie_i,
  input  wire logic [HCD_W-1:0]  rx_hib_countdown_i,
  input  wire logic [CNT_W-1:0]  rx_hib_duration_i,
  // superframe start and beacon build
  input  wire logic              sf_tick_i,
  input  wire logic              tx_beacon_sent_i,
  input  wire logic              master_net_i,
  output logic                   cap_anchor_o,
  output logic                   anchor_ie_present_o,
  output logic [ENTRIES-1:0]     entry_listed_o,
  // ahb-lite slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o
);
  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // register map, one aligned word each, answered with zero wait states:
  //   control      bit 0 capability on, bit 1 master default role enable
  //   status       bit 0 capability advertised, bit 1 anchor element present
  //   listed       one bit per table slot currently shown in the element
  //   entry select slot index for the entry window
  //   entry window [15:0] neighbour address, [23:16] wake-up countdown,
  //                [31:30] slot state
  // the master default bit leaves reset set, so a master is anchor with no
  // software help; clearing it is how software ends that role
  //
  // limitations worth knowing:
  //   a full table drops a newcomer silently; size it for the densest
  //   neighbourhood expected
  //   one receive event per cycle; the receive path must serialise beacons
  //   hsize is ignored, so a narrow write acts as a whole-word write
  //   unmapped words read as zero and swallow writes

  // per-slot table: free, pending (announced, not yet asleep) or sleeping;
  // pending exists so a neighbour whose last beacons are lost is still
  // promoted to sleeping on time
  anchor_pkg::entry_state_t state_q [ENTRIES];
  logic [ADDR_W-1:0] addr_q [ENTRIES];
  logic [CNT_W-1:0]  wake_q [ENTRIES];
  logic [CNT_W-1:0]  dur_q  [ENTRIES];
  logic [ENTRIES-1:0] sent_zero_q; // listed with zero countdown in a sent beacon
  logic [1:0]        ctrl_q;
  logic [IDX_W-1:0]  sel_q;
  logic              anchor_en;

  // match an address against the table, first hit wins
  // the free-slot search ignores the address; the lowest free slot is taken
  // so the entry window order follows arrival order while the table fills
  function automatic logic [IDX_W:0] find_addr(input logic [ADDR_W-1:0] a,
                                               input logic use_free);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (use_free ? (state_q[i] == anchor_pkg::ENTRY_FREE)
                   : (state_q[i] != anchor_pkg::ENTRY_FREE && addr_q[i] == a)) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // a slot is shown while it sleeps and its zero countdown has not gone out
  function automatic logic entry_shown(input int i);
    return anchor_en && state_q[i] == anchor_pkg::ENTRY_SLEEPING && !sent_zero_q[i];
  endfunction

  logic [IDX_W:0] hit;
  logic [IDX_W:0] free_slot;
  logic           ann_zero;
  logic           ann_near;
  always_comb begin
    hit       = find_addr(rx_addr_i, 1'b0);
    free_slot = find_addr(rx_addr_i, 1'b1);
    ann_zero  = rx_beacon_i && rx_hib_ie_i && (rx_hib_countdown_i == '0);
    ann_near  = rx_beacon_i && rx_hib_ie_i && (rx_hib_countdown_i != '0) &&
                (rx_hib_countdown_i <= HCD_W'(`ANC_LOST_BEACON_LIMIT));
  end

  // master role makes the device anchor even if software left capability off
  // capability bit and listing both follow anchor_en, so dropping the role
  // clears the advertised bit in the same beacon as the listing
  assign anchor_en = ctrl_q[`ANC_CTRL_CAPABLE] | (master_net_i & ctrl_q[`ANC_CTRL_MASTER]);

  // table update; tick is applied first so beacon contents follow it
  // ordering within one edge: the per-slot tick work is written first and
  // the receive work after it, so a beacon in a tick cycle wins for its own
  // slot; the reloaded countdown then starts its count at the next tick
  // turning the anchor role off empties the table at once, so a later
  // re-enable never shows stale sleepers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        state_q[i] <= anchor_pkg::ENTRY_FREE;
        addr_q[i]  <= '0;
        wake_q[i]  <= '0;
        dur_q[i]   <= '0;
      end
      sent_zero_q <= '0;
    end else if (clk_en_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (!anchor_en) begin
          state_q[i] <= anchor_pkg::ENTRY_FREE;
        end else begin
          case (state_q[i])
            anchor_pkg::ENTRY_FREE: ;
            anchor_pkg::ENTRY_PENDING: begin
              // countdown not yet seen at zero; missed beacons still promote it
              if (sf_tick_i && wake_q[i] != '0) begin
                wake_q[i] <= wake_q[i] - 1'b1;
              end else if (sf_tick_i) begin
                state_q[i] <= anchor_pkg::ENTRY_SLEEPING;
                wake_q[i]  <= dur_q[i];
              end
            end
            anchor_pkg::ENTRY_SLEEPING: begin
              if (sf_tick_i && wake_q[i] != '0) begin
                wake_q[i] <= wake_q[i] - 1'b1;
              end
              if (tx_beacon_sent_i && wake_q[i] == '0) begin
                sent_zero_q[i] <= 1'b1;
              end
              if (sent_zero_q[i]) begin
                state_q[i]     <= anchor_pkg::ENTRY_FREE;
                sent_zero_q[i] <= 1'b0;
              end
            end
            default: state_q[i] <= anchor_pkg::ENTRY_FREE;
          endcase
        end
      end
      // receive events override the tick for the addressed entry
      // a countdown above the limit is not tracked: the neighbour is still
      // expected to beacon and will announce again
      if (anchor_en && rx_beacon_i) begin
        if (ann_zero || ann_near) begin
          // reuse the existing slot rather than duplicating
          if (hit[IDX_W]) begin
            state_q[hit[IDX_W-1:0]]     <= ann_zero ? anchor_pkg::ENTRY_SLEEPING
                                                    : anchor_pkg::ENTRY_PENDING;
            wake_q[hit[IDX_W-1:0]]      <= ann_zero ? rx_hib_duration_i
                                                    : CNT_W'(rx_hib_countdown_i);
            dur_q[hit[IDX_W-1:0]]       <= rx_hib_duration_i;
            sent_zero_q[hit[IDX_W-1:0]] <= 1'b0;
          end else if (free_slot[IDX_W]) begin
            // full table drops the newcomer; capacity is a parameter
            state_q[free_slot[IDX_W-1:0]] <= ann_zero ? anchor_pkg::ENTRY_SLEEPING
                                                      : anchor_pkg::ENTRY_PENDING;
            addr_q[free_slot[IDX_W-1:0]]  <= rx_addr_i;
            wake_q[free_slot[IDX_W-1:0]]  <= ann_zero ? rx_hib_duration_i
                                                      : CNT_W'(rx_hib_countdown_i);
            dur_q[free_slot[IDX_W-1:0]]   <= rx_hib_duration_i;
            sent_zero_q[free_slot[IDX_W-1:0]] <= 1'b0;
          end
        end else if (hit[IDX_W] && state_q[hit[IDX_W-1:0]] == anchor_pkg::ENTRY_SLEEPING) begin
          // plain beacon from a sleeper: it woke early
          state_q[hit[IDX_W-1:0]]     <= anchor_pkg::ENTRY_FREE;
          sent_zero_q[hit[IDX_W-1:0]] <= 1'b0;
        end else if (hit[IDX_W]) begin
          state_q[hit[IDX_W-1:0]] <= anchor_pkg::ENTRY_FREE;
        end
      end
    end
  end

  // beacon view, registered
  // registered so the beacon builder sees levels that move only on an edge;
  // the element flag is built from the same condition as the listing, so
  // the two never disagree
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cap_anchor_o        <= 1'b0;
      anchor_ie_present_o <= 1'b0;
      entry_listed_o      <= '0;
    end else if (clk_en_i) begin
      cap_anchor_o <= anchor_en;
      for (int i = 0; i < ENTRIES; i++) begin
        entry_listed_o[i] <= entry_shown(i);
      end
      anchor_ie_present_o <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        if (entry_shown(i)) begin
          anchor_ie_present_o <= 1'b1;
        end
      end
    end
  end

  // ahb-lite: zero wait states, always okay
  logic        dph_wr_q;
  logic        dph_rd_q;
  logic [31:0] dph_addr_q;
  logic        addr_ok;
  // only nonseq or seq with hsel and hready open a transfer; idle and busy
  // leave the data-phase flags low so nothing is written by accident
  assign addr_ok = hsel_i && hready_i && htrans_i[1];

  // no wait states and no error responses, so both bus outputs stay fixed
  // after reset; they are still flops to keep every output registered

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dph_wr_q   <= 1'b0;
      dph_rd_q   <= 1'b0;
      dph_addr_q <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (clk_en_i) begin
      dph_wr_q   <= addr_ok && hwrite_i;
      dph_rd_q   <= addr_ok && !hwrite_i;
      if (addr_ok) begin
        dph_addr_q <= haddr_i;
      end
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // register writes in the data phase
  // only the two control bits and the select exist; other write bits drop
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= `ANC_CTRL_RESET_VAL;
      sel_q  <= '0;
    end else if (clk_en_i && dph_wr_q) begin
      if (dph_addr_q == `ANC_REG_CTRL) begin
        ctrl_q <= hwdata_i[1:0];
      end
      if (dph_addr_q == `ANC_REG_ENTRY_SEL) begin
        sel_q <= hwdata_i[IDX_W-1:0];
      end
    end
  end

  // read mux, registered on the address phase so data stands in the data phase
  // status bits are the registered beacon view, so they lag the table by
  // one cycle, the same as the beacon builder sees them
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr_i)
      `ANC_REG_CTRL:   rd_d[1:0] = ctrl_q;
      `ANC_REG_STATUS: begin
        rd_d[0] = cap_anchor_o;
        rd_d[1] = anchor_ie_present_o;
      end
      `ANC_REG_VALID:  rd_d[ENTRIES-1:0] = entry_listed_o;
      `ANC_REG_ENTRY_SEL: rd_d[IDX_W-1:0] = sel_q;
      `ANC_REG_ENTRY_DATA: begin
        rd_d[ADDR_W-1:0]        = addr_q[sel_q];
        rd_d[ADDR_W+:CNT_W]     = wake_q[sel_q];
        rd_d[31:30]             = 2'(state_q[sel_q]);
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (clk_en_i && addr_ok && !hwrite_i) begin
      hrdata_o <= rd_d;
    end
  end
endmodule // hibernation_anchor_tracker

// ### sim/anchor_props.sv
// assertion checker for the hibernation anchor tracker ports
`timescale 1ns/100ps
module anchor_props #(
  parameter int ENTRIES = 8
) (
  input wire logic               core_clk_i,
  input wire logic               reset_i,
  input wire logic               clk_en_i,
  input wire logic               rx_beacon_i,
  input wire logic               rx_hib_ie_i,
  input wire logic [7:0]         rx_hib_countdown_i,
  input wire logic               sf_tick_i,
  input wire logic               tx_beacon_sent_i,
  input wire logic               hsel_i,
  input wire logic [31:0]        haddr_i,
  input wire logic [1:0]         htrans_i,
  input wire logic               hwrite_i,
  input wire logic               hready_i,
  input wire logic               cap_anchor_o,
  input wire logic               anchor_ie_present_o,
  input wire logic [ENTRIES-1:0] entry_listed_o,
  input wire logic [31:0]        hrdata_o,
  input wire logic               hreadyout_o,
  input wire logic               hresp_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // announcement taken, then a quiet cycle so nothing else competes
  sequence s_zero_rx;
    rx_beacon_i && rx_hib_ie_i && rx_hib_countdown_i == 8'h00 && clk_en_i && cap_anchor_o
      && !sf_tick_i && !tx_beacon_sent_i ##1 clk_en_i && !sf_tick_i && !tx_beacon_sent_i;
  endsequence
  property p_add; s_zero_rx |-> ##[1:2] anchor_ie_present_o; endproperty
  property p_noie; (entry_listed_o == '0) [*3] |-> !anchor_ie_present_o; endproperty
  property p_capoff; (!cap_anchor_o) [*3] |-> entry_listed_o == '0 && !anchor_ie_present_o;
  endproperty
  property p_freeze;
    !clk_en_i |=> $stable(entry_listed_o) && $stable(cap_anchor_o) && $stable(hrdata_o);
  endproperty
  // unmapped word must read as zero in the data phase
  property p_unmap;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == 32'h0000_0020 && clk_en_i
      |=> hrdata_o == 32'h0000_0000;
  endproperty
  property p_resp; hresp_o == 1'b0; endproperty
  property p_ready; hreadyout_o == 1'b1; endproperty
  property p_rst;
    $fell(reset_i) |-> !cap_anchor_o && entry_listed_o == '0 && hrdata_o == 32'h0000_0000;
  endproperty
  a_add: assert property (p_add) else $error("no anchor element after announcement");
  a_noie: assert property (p_noie) else $error("element present with empty list");
  a_capoff: assert property (p_capoff) else $error("listing while not anchor");
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_resp: assert property (p_resp) else $error("bus response not okay");
  a_ready: assert property (p_ready) else $error("bus wait state seen");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // anchor_props
bind hibernation_anchor_tracker anchor_props #(.ENTRIES(ENTRIES)) u_props (
  .core_clk_i, .reset_i, .clk_en_i, .rx_beacon_i, .rx_hib_ie_i, .rx_hib_countdown_i,
  .sf_tick_i, .tx_beacon_sent_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .cap_anchor_o, .anchor_ie_present_o, .entry_listed_o, .hrdata_o, .hreadyout_o, .hresp_o);

// ### sim/neighbour_model.sv
// neighbour device model: beacons with or without a hibernation announcement
`timescale 1ns/100ps
module neighbour_model (
  input  wire logic  core_clk_i,
  output logic       rx_beacon_o,
  output logic [15:0] rx_addr_o,
  output logic       rx_hib_ie_o,
  output logic [7:0] rx_hib_countdown_o,
  output logic [7:0] rx_hib_duration_o
);
  // one beacon per call; fields scrambled once it is gone so stale values never match
  task automatic send(input logic [15:0] a, input logic ie, input logic [7:0] cd,
                      input logic [7:0] dur);
    @(posedge core_clk_i);
    rx_beacon_o <= 1'b1;
    rx_addr_o <= a;
    rx_hib_ie_o <= ie;
    rx_hib_countdown_o <= cd;
    rx_hib_duration_o <= (dur == 8'h00) ? 8'h01 : dur;
    @(posedge core_clk_i);
    rx_beacon_o <= 1'b0;
    rx_addr_o <= ~a;
    rx_hib_ie_o <= ~ie;
    rx_hib_countdown_o <= ~cd;
    rx_hib_duration_o <= ~dur;
  endtask
  initial rx_beacon_o = 1'b0;
endmodule // neighbour_model

// ### sim/hibernation_anchor_tracker_tb_top.sv
// self-checking bench for the hibernation anchor tracker
`timescale 1ns/100ps
`include "anchor_defines.svh"
module hibernation_anchor_tracker_tb_top;
  logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sf_tick = 1'b0, tx_sent = 1'b0;
  logic        master = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_beacon, rx_ie;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [15:0] rx_addr, a;
  logic [7:0]  rx_cd, rx_dur, listed, v, dur;
  logic        cap, ie, hreadyout, hresp;
  logic [31:0] probe [4] = '{`ANC_REG_CTRL, `ANC_REG_STATUS, `ANC_REG_VALID, 32'h0000_0020};
  integer      seed = 34;
  int          err_total = 0, check_count = 0;
  always #5 clk = ~clk;
  neighbour_model u_nbr (.core_clk_i(clk), .rx_beacon_o(rx_beacon), .rx_addr_o(rx_addr),
    .rx_hib_ie_o(rx_ie), .rx_hib_countdown_o(rx_cd), .rx_hib_duration_o(rx_dur));
  hibernation_anchor_tracker DUT (.core_clk_i(clk), .reset_i(rst), .clk_en_i(clk_en),
    .rx_beacon_i(rx_beacon), .rx_addr_i(rx_addr), .rx_hib_ie_i(rx_ie),
    .rx_hib_countdown_i(rx_cd), .rx_hib_duration_i(rx_dur), .sf_tick_i(sf_tick),
    .tx_beacon_sent_i(tx_sent), .master_net_i(master), .cap_anchor_o(cap),
    .anchor_ie_present_o(ie), .entry_listed_o(listed), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp));
  // expected status word and entry count
  function automatic logic [31:0] stat(input logic c, input logic e);
    return {30'h0, e, c};
  endfunction
  function automatic logic [31:0] cnt(input logic [7:0] x);
    cnt = 32'h0;
    foreach (x[i]) cnt += {31'h0, x[i]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single ahb-lite transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // n one-cycle pulses of superframe tick (tk) or beacon sent
  task automatic step(input int n, input logic tk);
    repeat (n) begin
      @(posedge clk);
      if (tk) sf_tick <= 1'b1;
      else tx_sent <= 1'b1;
      @(posedge clk);
      sf_tick <= 1'b0;
      tx_sent <= 1'b0;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (probe[i]) begin
      bus(1'b0, probe[i], 32'h0);
      chk(rd, (probe[i] == `ANC_REG_CTRL) ? 32'(`ANC_CTRL_RESET_VAL) : 32'h0);
    end
    master <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, cap}, 32'h1);
    master <= 1'b0;
    bus(1'b1, `ANC_REG_CTRL, 32'h1);
    bus(1'b0, `ANC_REG_STATUS, 32'h0);
    chk(rd, stat(1'b1, 1'b0));
    a = 16'($random(seed));
    dur = 8'h02 + 8'($random(seed) & 3);
    u_nbr.send(a, 1'b1, 8'h00, dur);
    repeat (3) @(posedge clk);
    chk({31'h0, ie}, 32'h1);
    u_nbr.send(a, 1'b1, 8'h00, dur);
    repeat (3) @(posedge clk);
    chk(cnt(listed), 32'h1);
    step(dur - 1, 1'b1);
    step(1, 1'b0);
    repeat (4) @(posedge clk);
    chk({31'h0, ie}, 32'h1);
    bus(1'b0, `ANC_REG_ENTRY_DATA, 32'h0);
    chk(rd, {2'(anchor_pkg::ENTRY_SLEEPING), 6'h00, 8'h01, a});
    step(2, 1'b1);
    step(1, 1'b0);
    repeat (4) @(posedge clk);
    chk({31'h0, ie}, 32'h0);
    bus(1'b0, `ANC_REG_STATUS, 32'h0);
    chk(rd, stat(1'b1, 1'b0));
    u_nbr.send(a ^ 16'h1, 1'b1, 8'h00, dur);
    u_nbr.send(a ^ 16'h1, 1'b0, 8'h00, dur);
    repeat (4) @(posedge clk);
    chk(cnt(listed), 32'h0);
    u_nbr.send(a ^ 16'h2, 1'b1, {4'h0, `ANC_LOST_BEACON_LIMIT}, dur);
    step(4, 1'b1);
    repeat (3) @(posedge clk);
    chk({31'h0, ie}, 32'h1);
    v = listed;
    clk_en <= 1'b0;
    u_nbr.send(a ^ 16'h3, 1'b1, 8'h00, dur);
    repeat (2) @(posedge clk);
    chk({24'h0, listed}, {24'h0, v});
    clk_en <= 1'b1;
    bus(1'b1, `ANC_REG_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk({30'h0, cap, ie}, 32'h0);
    master <= 1'b1;
    bus(1'b1, `ANC_REG_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, cap}, 32'h1);
    u_nbr.send(a, 1'b1, 8'h00, dur);
    repeat (3) @(posedge clk);
    chk({31'h0, ie}, 32'h1);
    master <= 1'b0;
    repeat (3) @(posedge clk);
    chk({30'h0, cap, ie}, 32'h0);
    report_and_stop;
  end
  // watchdog against a hung handshake
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
endmodule // hibernation_anchor_tracker_tb_top
